// >>> pkg/irbm_pkg.sv
// Package for the infrared port baud and mode control register bank
package irbm_pkg;

  // Register indices; byte address is four times the index
  localparam logic [2:0] IDX_DIV_LOW     = 3'h0;
  localparam logic [2:0] IDX_DIV_HIGH    = 3'h1;
  localparam logic [2:0] IDX_ADV_CTRL1   = 3'h2;
  localparam logic [2:0] IDX_SET_SELECT  = 3'h3;
  localparam logic [2:0] IDX_HANDSHAKE   = 3'h4;
  localparam logic [2:0] IDX_ADV_CTRL2   = 3'h4;
  localparam logic [2:0] IDX_TX_FILL     = 3'h6;
  localparam logic [2:0] IDX_RX_FILL     = 3'h7;
  localparam logic [2:0] IDX_SCRATCH     = 3'h7;

  // Set select codes
  localparam logic [7:0] SSR_SET2        = 8'he0;
  localparam logic [7:0] SSR_SET3        = 8'he4;
  localparam logic [7:0] SSR_SET4        = 8'he8;
  localparam logic [7:0] SSR_SET5        = 8'hec;
  localparam logic [7:0] SSR_SET6        = 8'hf0;
  localparam logic [7:0] SSR_SET7        = 8'hf4;
  localparam logic [7:0] SSR_RESET       = 8'he0;
  localparam logic [7:0] SSR_SET2_READ   = 8'he0;

  // Reset values
  localparam logic [7:0] ADVANCED_CONTROL_ONE_RESET     = 8'h00;
  localparam logic [7:0] ADVANCED_CONTROL_TWO_RESET     = 8'h00;
  localparam logic [7:0] HCR_RESET       = 8'h60;

  // advanced_control_one fields
  localparam int B_BAUD_OUT   = 7;
  localparam int B_LOOP_DRIVE = 5;
  localparam int B_UNIVERSAL_LOOPBACK      = 4;
  localparam int B_DMA_SWAP   = 3;
  localparam int B_DMA_THR    = 2;
  localparam int B_DMA_FAIR   = 1;
  localparam int B_ADV_EN     = 0;
  // advanced_control_two fields
  localparam int B_FB_DIS     = 7;
  localparam int PRESC_LSB    = 4;
  localparam int RXSZ_LSB     = 2;
  localparam int TXSZ_LSB     = 0;
  // handshake_control_reg fields
  localparam int MODE_LSB     = 5;
  localparam int B_XLOOP      = 4;
  localparam int B_DTR        = 0;

  // Fall-back clear masks
  localparam logic [7:0] ADVANCED_CONTROL_ONE_ADV_CLR   = 8'ha1;
  localparam logic [7:0] ADVANCED_CONTROL_ONE_LEG_CLR   = 8'ha0;
  localparam logic [7:0] HCR_MODE_CLR    = 8'he0;
  localparam logic [7:0] SSR_FB_CLR      = 8'h0c;

  // FIFO size codes and DMA thresholds
  localparam logic [1:0] FSZ_32          = 2'h1;
  localparam logic [5:0] TX_THR_LOW      = 6'h0d;
  localparam logic [5:0] RX_THR_LOW      = 6'h04;
  localparam logic [5:0] RX_THR_HIGH     = 6'h0a;
  localparam logic [5:0] TX_THR_HIGH16   = 6'h07;
  localparam logic [5:0] TX_THR_HIGH32   = 6'h17;

  // Pre-divisor as modulus/step: 13/1, 13/8, 13/2, 13/13
  localparam logic [4:0] PRE_MOD         = 5'h0d;
  localparam logic [4:0] PRE_STEP_13     = 5'h01;
  localparam logic [4:0] PRE_STEP_1625   = 5'h08;
  localparam logic [4:0] PRE_STEP_65     = 5'h02;
  localparam logic [4:0] PRE_STEP_1      = 5'h0d;

  // Timing
  localparam int CLK_FREQ_MHZ            = 250;
  localparam int FAIR_TIME_NS            = 10500;
  localparam logic [11:0] FAIR_CYCLES    =
    12'(FAIR_TIME_NS * CLK_FREQ_MHZ / 1000);

  localparam logic [1:0] RESP_OKAY       = 2'h0;
  localparam logic [1:0] RESP_SLVERR     = 2'h2;

  typedef enum logic [2:0] {
    SET0, SET1, SET2, SET3, SET4, SET5, SET6, SET7
  } irbm_set_t;

  typedef struct packed {
    logic tx;
    logic rx;
    logic single;
  } irbm_dma_req_t;

  typedef struct packed {
    logic [5:0] tx_thr;
    logic [5:0] rx_thr;
    logic       tx32;
    logic       rx32;
  } irbm_fifo_cfg_t;

  function automatic irbm_set_t irbm_decode_set(input logic [7:0] v);
    if (!v[7]) begin
      return SET0;
    end
    unique case (v)
      SSR_SET2: return SET2;
      SSR_SET3: return SET3;
      SSR_SET4: return SET4;
      SSR_SET5: return SET5;
      SSR_SET6: return SET6;
      SSR_SET7: return SET7;
      default:  return SET1;
    endcase
  endfunction : irbm_decode_set

endpackage : irbm_pkg

// >>> design/irbm_top.sv
// Infrared port baud and mode control register bank with AXI4-Lite slave
// Behaviour
// R1 - Legacy divisor read or write in advanced mode falls back to legacy SIR.
// R2 - Fall-back clears mode field, control-one bits 0,5,7, set-select bits 2,3.
// R3 - Fall-back disabled in legacy mode leaves all registers unchanged.
// R4 - Set 1 offsets 2 to 7 behave as set 0 offsets.
// R5 - Advanced divisor bytes act as legacy divisor without any fall-back.
// R6 - Baud test bit drives generated baud clock onto the DTR pin.
// R7 - Loopback pin drive bit keeps transmit data on infrared pin in loopback.
// R8 - Universal loopback bit loops transmit data to receiver in all modes; code honours it only in advanced mode.
// R9 - Swap bit gives a single DMA channel to receiver (0) or transmitter (1).
// R10 - Trigger bit picks thresholds: tx 13 rx 4, or rx 10 tx 7/23.
// R11 - Fairness bit 0 forces DMA request low after 10.5 us asserted.
// R12 - Writing advanced enable bit to 1 enters advanced mode.
// R13 - Set 2 offset 3 reads E0; write selects register set.
// R14 - Fall-back disable bit blocks fall-back to legacy mode.
// R15 - Prescale field picks pre-divisor 13, 1.625, 6.5 or 1.
// R16 - Pre-divided clock, not raw input, feeds the baud divisor.
// R17 - Receive FIFO size field: 00 is 16 bytes, 01 is 32 bytes.
// R18 - Software writes zero to bit 6 of both advanced control registers.
// R19 - Set 2 registers take effect only in advanced mode.
// R20 - Fall-back resets the advanced mode field to zero.
// R21 - Transmit FIFO size field: 00 is 16 bytes, 01 is 32 bytes.
// R22 - Low and high divisor bytes form one 16-bit divisor.
//
// Chosen here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module irbm_top (
  input  wire logic                    aclk,
  input  wire logic                    aresetn,
  input  wire logic [11:0]             s_axi_awaddr,
  input  wire logic                    s_axi_awvalid,
  output logic                         s_axi_awready,
  input  wire logic [31:0]             s_axi_wdata,
  input  wire logic [3:0]              s_axi_wstrb,
  input  wire logic                    s_axi_wvalid,
  output logic                         s_axi_wready,
  output logic [1:0]                   s_axi_bresp,
  output logic                         s_axi_bvalid,
  input  wire logic                    s_axi_bready,
  input  wire logic [11:0]             s_axi_araddr,
  input  wire logic                    s_axi_arvalid,
  output logic                         s_axi_arready,
  output logic [31:0]                  s_axi_rdata,
  output logic [1:0]                   s_axi_rresp,
  output logic                         s_axi_rvalid,
  input  wire logic                    s_axi_rready,
  input  wire logic                    clk24_pin,
  input  wire logic                    ir_rx_pin,
  input  wire logic                    tx_bit,
  input  wire logic [5:0]              tx_fill_level,
  input  wire logic [5:0]              rx_fill_level,
  input  wire irbm_pkg::irbm_dma_req_t dma_req,
  output logic                         infrared_transmit_pin,
  output logic                         dtr_pin,
  output logic                         rx_bit,
  output logic                         dma_req_ch0,
  output logic                         dma_req_ch1,
  output irbm_pkg::irbm_fifo_cfg_t     fifo_cfg,
  output logic [2:0]                   advanced_mode_field,
  output logic                         advanced_enable
);
  import irbm_pkg::*;

  typedef struct packed {
    logic [7:0]     div_lo;
    logic [7:0]     div_hi;
    logic [7:0]     advanced_control_one;
    logic [7:0]     advanced_control_two;
    logic [7:0]     register_set_select;
    logic [7:0]     handshake_control_reg;
    logic [7:0]     scratch;
    logic           aw_got;
    logic [2:0]     aw_idx;
    logic           aw_bad;
    logic           w_got;
    logic [7:0]     wdata;
    logic           wlane;
    logic           awready;
    logic           wready;
    logic           bvalid;
    logic [1:0]     bresp;
    logic           arready;
    logic           rvalid;
    logic [7:0]     rdata;
    logic [1:0]     rresp;
    logic           clk_s1;
    logic           clk_s2;
    logic           clk_s3;
    logic           rx_s1;
    logic           rx_s2;
    logic [4:0]     pre_acc;
    logic           pre_tick;
    logic [15:0]    div_cnt;
    logic           baud_clk;
    logic [11:0]    fair_cnt;
    logic           dtr;
    logic           ir_tx;
    logic           rx_loop;
    logic           dma_ch0;
    logic           dma_ch1;
    irbm_fifo_cfg_t cfg;
    logic [2:0]     mode;
    logic           adv;
  } irbm_state_t;

  irbm_state_t st_q;
  irbm_state_t st_d;

  localparam irbm_state_t ST_RESET = '{
    advanced_control_one: ADVANCED_CONTROL_ONE_RESET, advanced_control_two: ADVANCED_CONTROL_TWO_RESET, register_set_select: SSR_RESET,
    handshake_control_reg: HCR_RESET, cfg: '{tx_thr: TX_THR_LOW, rx_thr: RX_THR_LOW,
                           tx32: 1'b0, rx32: 1'b0},
    default: '0
  };

  ////////////////////////////////////////////////////////////////////////////
  // Decode and effective controls
  irbm_set_t   set_w;
  irbm_set_t   set_r;
  logic        do_wr;
  logic        wr_en;
  logic        ar_take;
  logic        ar_bad;
  logic [2:0]  ar_idx;
  logic        leg_acc;
  logic        adv;
  logic        fb_dis;
  logic        fb_adv;
  logic        fb_leg;
  logic [15:0] divisor;
  logic [1:0]  presc_sel;
  logic [4:0]  pre_step;
  logic [4:0]  pre_sum;
  logic        clk_edge;
  logic        loop_on;
  logic        raw_ch0;
  logic        raw_ch1;
  logic        fair_off;

  assign set_w    = irbm_decode_set(st_q.register_set_select);
  assign set_r    = irbm_decode_set(st_q.register_set_select);
  assign do_wr    = st_q.aw_got & st_q.w_got & ~st_q.bvalid;
  assign wr_en    = do_wr & ~st_q.aw_bad & st_q.wlane;
  assign ar_take  = s_axi_arvalid & st_q.arready;
  assign ar_bad   = |s_axi_araddr[11:5];
  assign ar_idx   = s_axi_araddr[4:2];
  assign adv      = st_q.advanced_control_one[B_ADV_EN];
  // Only the disable bit itself is honoured outside advanced mode
  assign fb_dis   = st_q.advanced_control_two[B_FB_DIS];
  assign leg_acc  =
    (do_wr & ~st_q.aw_bad & (set_w == SET1) & (st_q.aw_idx <= IDX_DIV_HIGH))
    | (ar_take & ~ar_bad & (set_r == SET1) & (ar_idx <= IDX_DIV_HIGH));
  assign fb_adv   = leg_acc & adv & ~fb_dis;             // R1
  assign fb_leg   = leg_acc & ~adv & ~fb_dis;            // R3
  assign divisor  = {st_q.div_hi, st_q.div_lo};          // R22
  assign presc_sel = adv ? st_q.advanced_control_two[PRESC_LSB +: 2] : 2'h0; // R19
  assign clk_edge = st_q.clk_s2 & ~st_q.clk_s3;
  assign pre_sum  = st_q.pre_acc + pre_step;
  assign loop_on  = (adv & st_q.advanced_control_one[B_UNIVERSAL_LOOPBACK])          // R8
                    | (~adv & st_q.handshake_control_reg[B_XLOOP]);
  assign fair_off = adv & st_q.advanced_control_one[B_DMA_FAIR];

  always_comb begin
    unique case (presc_sel)                              // R15
      2'h0: pre_step = PRE_STEP_13;
      2'h1: pre_step = PRE_STEP_1625;
      2'h2: pre_step = PRE_STEP_65;
      2'h3: pre_step = PRE_STEP_1;
    endcase
  end

  // Single channel carries the side the swap bit selects in advanced mode, else the receiver
  always_comb begin
    if (dma_req.single) begin
      raw_ch0 = (adv & st_q.advanced_control_one[B_DMA_SWAP]) ? dma_req.tx : dma_req.rx; // R9
      raw_ch1 = 1'b0;
    end else begin
      raw_ch0 = dma_req.rx;
      raw_ch1 = dma_req.tx;
    end
  end

  function automatic logic [7:0] read_mux(input irbm_set_t s,
                                          input logic [2:0] i);
    logic [7:0] v;
    v = 8'h00;
    if (i == IDX_SET_SELECT) begin
      v = (s == SET2) ? SSR_SET2_READ : st_q.register_set_select;        // R13
    end else if (s == SET0 || s == SET1) begin           // R4
      if (i == IDX_HANDSHAKE) v = st_q.handshake_control_reg;
      else if (i == IDX_SCRATCH) v = st_q.scratch;
      else if (s == SET1 && i == IDX_DIV_LOW) v = st_q.div_lo;
      else if (s == SET1 && i == IDX_DIV_HIGH) v = st_q.div_hi;
    end else if (s == SET2) begin
      unique case (i)
        IDX_DIV_LOW:   v = st_q.div_lo;
        IDX_DIV_HIGH:  v = st_q.div_hi;
        IDX_ADV_CTRL1: v = st_q.advanced_control_one;
        IDX_ADV_CTRL2: v = st_q.advanced_control_two;
        IDX_TX_FILL:   v = {2'h0, tx_fill_level};
        IDX_RX_FILL:   v = {2'h0, rx_fill_level};
        default:       v = 8'h00;
      endcase
    end
    return v;
  endfunction : read_mux

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    st_d = st_q;
    st_d.pre_tick = 1'b0;

    if (s_axi_awvalid && st_q.awready) begin
      st_d.aw_got = 1'b1;
      st_d.aw_idx = s_axi_awaddr[4:2];
      st_d.aw_bad = |s_axi_awaddr[11:5];
    end
    if (s_axi_wvalid && st_q.wready) begin
      st_d.w_got = 1'b1;
      st_d.wdata = s_axi_wdata[7:0];
      st_d.wlane = s_axi_wstrb[0];
    end
    if (st_q.bvalid && s_axi_bready) begin
      st_d.bvalid = 1'b0;
    end
    if (do_wr) begin
      st_d.aw_got = 1'b0;
      st_d.w_got  = 1'b0;
      st_d.bvalid = 1'b1;
      st_d.bresp  = st_q.aw_bad ? RESP_SLVERR : RESP_OKAY;
    end

    if (wr_en) begin
      if (st_q.aw_idx == IDX_SET_SELECT) begin
        st_d.register_set_select = st_q.wdata;                           // R13
      end else if (set_w == SET0 || set_w == SET1) begin // R4
        if (st_q.aw_idx == IDX_HANDSHAKE) st_d.handshake_control_reg = st_q.wdata;
        else if (st_q.aw_idx == IDX_SCRATCH) st_d.scratch = st_q.wdata;
        else if (set_w == SET1 && st_q.aw_idx == IDX_DIV_LOW)
          st_d.div_lo = st_q.wdata;
        else if (set_w == SET1 && st_q.aw_idx == IDX_DIV_HIGH)
          st_d.div_hi = st_q.wdata;
      end else if (set_w == SET2) begin
        // Advanced divisor shares the latch but never falls back
        if (st_q.aw_idx == IDX_DIV_LOW && adv) st_d.div_lo = st_q.wdata; // R5
        else if (st_q.aw_idx == IDX_DIV_HIGH && adv)
          st_d.div_hi = st_q.wdata;                      // R19
        else if (st_q.aw_idx == IDX_ADV_CTRL1)
          st_d.advanced_control_one = st_q.wdata;                       // R12
        else if (st_q.aw_idx == IDX_ADV_CTRL2)
          st_d.advanced_control_two = st_q.wdata;                       // R14
      end
    end

    if (ar_take) begin
      st_d.rvalid = 1'b1;
      st_d.rresp  = ar_bad ? RESP_SLVERR : RESP_OKAY;
      st_d.rdata  = ar_bad ? 8'h00 : read_mux(set_r, ar_idx);
    end
    if (st_q.rvalid && s_axi_rready) begin
      st_d.rvalid = 1'b0;
    end
    st_d.awready = ~st_d.aw_got & ~st_d.bvalid;
    st_d.wready  = ~st_d.w_got & ~st_d.bvalid;
    st_d.arready = ~st_d.rvalid;

    // Fall-back applied after the write so its clears win
    if (fb_adv) begin
      st_d.handshake_control_reg   = st_d.handshake_control_reg & ~HCR_MODE_CLR;             // R20
      st_d.advanced_control_one = st_d.advanced_control_one & ~ADVANCED_CONTROL_ONE_ADV_CLR;          // R2
      st_d.register_set_select   = st_d.register_set_select & ~SSR_FB_CLR;               // R2
    end
    if (fb_leg) begin
      st_d.advanced_control_one = st_d.advanced_control_one & ~ADVANCED_CONTROL_ONE_LEG_CLR;          // R2
    end

    // Pin samplers; stage one feeds only stage two
    st_d.clk_s1 = clk24_pin;
    st_d.clk_s2 = st_q.clk_s1;
    st_d.clk_s3 = st_q.clk_s2;
    st_d.rx_s1  = ir_rx_pin;
    st_d.rx_s2  = st_q.rx_s1;

    // Fractional pre-divider on the sampled 24 MHz edges
    if (clk_edge) begin
      if (pre_sum >= PRE_MOD) begin
        st_d.pre_acc  = pre_sum - PRE_MOD;
        st_d.pre_tick = 1'b1;                            // R15
      end else begin
        st_d.pre_acc  = pre_sum;
      end
    end

    // Divisor counts pre-divided ticks only; zero acts as one
    if (st_q.pre_tick) begin                             // R16
      if (st_q.div_cnt + 16'h0001 >= divisor) begin      // R22
        st_d.div_cnt  = 16'h0000;
        st_d.baud_clk = ~st_q.baud_clk;
      end else begin
        st_d.div_cnt  = st_q.div_cnt + 16'h0001;
      end
    end

    st_d.dtr = (adv & st_q.advanced_control_one[B_BAUD_OUT]) ? st_d.baud_clk // R6
                                              : st_q.handshake_control_reg[B_DTR];
    // Loopback idles the infrared pin unless advanced mode has the drive bit set
    if (loop_on) begin
      st_d.ir_tx   = (adv & st_q.advanced_control_one[B_LOOP_DRIVE]) & tx_bit; // R7
      st_d.rx_loop = tx_bit;                             // R8
    end else begin
      st_d.ir_tx   = tx_bit;
      st_d.rx_loop = st_q.rx_s2;
    end

    // Fairness timer runs while any request is held
    if (raw_ch0 || raw_ch1) begin
      if (st_q.fair_cnt != FAIR_CYCLES) begin
        st_d.fair_cnt = st_q.fair_cnt + 12'h001;
      end
    end else begin
      st_d.fair_cnt = 12'h000;
    end
    st_d.dma_ch0 = raw_ch0 & (fair_off | (st_q.fair_cnt != FAIR_CYCLES)); // R11
    st_d.dma_ch1 = raw_ch1 & (fair_off | (st_q.fair_cnt != FAIR_CYCLES));

    if (adv && st_q.advanced_control_one[B_DMA_THR]) begin              // R10
      st_d.cfg.rx_thr = RX_THR_HIGH;
      st_d.cfg.tx_thr = (st_q.advanced_control_two[TXSZ_LSB +: 2] == FSZ_32) ? TX_THR_HIGH32
                                                            : TX_THR_HIGH16;
    end else begin
      st_d.cfg.rx_thr = RX_THR_LOW;
      st_d.cfg.tx_thr = TX_THR_LOW;
    end
    st_d.cfg.rx32 = adv & (st_q.advanced_control_two[RXSZ_LSB +: 2] == FSZ_32); // R17
    st_d.cfg.tx32 = adv & (st_q.advanced_control_two[TXSZ_LSB +: 2] == FSZ_32); // R21
    st_d.mode = adv ? st_q.handshake_control_reg[MODE_LSB +: 3] : 3'h0;
    st_d.adv  = adv;                                     // R12
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= ST_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign s_axi_awready         = st_q.awready;
  assign s_axi_wready          = st_q.wready;
  assign s_axi_bresp           = st_q.bresp;
  assign s_axi_bvalid          = st_q.bvalid;
  assign s_axi_arready         = st_q.arready;
  assign s_axi_rdata           = {24'h000000, st_q.rdata};
  assign s_axi_rresp           = st_q.rresp;
  assign s_axi_rvalid          = st_q.rvalid;
  assign infrared_transmit_pin = st_q.ir_tx;
  assign dtr_pin               = st_q.dtr;
  assign rx_bit                = st_q.rx_loop;
  assign dma_req_ch0           = st_q.dma_ch0;
  assign dma_req_ch1           = st_q.dma_ch1;
  assign fifo_cfg              = st_q.cfg;
  assign advanced_mode_field   = st_q.mode;
  assign advanced_enable       = st_q.adv;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_set2_sel_read;
    ar_take && !ar_bad && set_r == SET2 && ar_idx == IDX_SET_SELECT;
  endsequence
  sequence s_sel_answer;
    st_q.rvalid && st_q.rdata == SSR_SET2_READ && st_q.rresp == RESP_OKAY;
  endsequence

  AST_FB_ADV_EXIT: assert property ( // R1
    fb_adv |=> !st_q.advanced_control_one[B_ADV_EN] ##1 !advanced_enable)
    else $error("fall-back did not leave advanced mode");
  AST_FB_ADV_CLEAR: assert property ( // R2
    fb_adv |=> st_q.handshake_control_reg[7:5] == 3'h0 && st_q.advanced_control_one[7] == 1'b0
               && st_q.advanced_control_one[5] == 1'b0 && st_q.register_set_select[3:2] == 2'h0)
    else $error("advanced fall-back left bits set");
  AST_FB_LEG_CLEAR: assert property ( // R2
    fb_leg |=> st_q.advanced_control_one[7] == 1'b0 && st_q.advanced_control_one[5] == 1'b0)
    else $error("legacy fall-back left bits set");
  AST_FB_DISABLED: assert property ( // R3
    leg_acc && !adv && fb_dis && !(wr_en && set_w == SET2)
      |=> $stable(st_q.advanced_control_one) && $stable(st_q.handshake_control_reg))
    else $error("disabled fall-back changed registers");
  AST_SET2_SELECT_READ: assert property ( // R13
    s_set2_sel_read |=> s_sel_answer)
    else $error("set 2 select read not E0");
  AST_ADV_DIV_LOCKED: assert property ( // R19
    wr_en && set_w == SET2 && st_q.aw_idx == IDX_DIV_LOW && !adv
      |=> $stable(st_q.div_lo))
    else $error("advanced divisor written outside advanced mode");
  AST_BAUD_ON_DTR: assert property ( // R6
    adv && st_q.advanced_control_one[B_BAUD_OUT] |=> dtr_pin == st_q.baud_clk)
    else $error("baud clock not on dtr pin");
  AST_LOOP_RX: assert property ( // R8
    adv && st_q.advanced_control_one[B_UNIVERSAL_LOOPBACK] |=> rx_bit == $past(tx_bit))
    else $error("loopback did not return transmit data");
  AST_LOOP_PIN_IDLE: assert property ( // R7
    loop_on && !(adv && st_q.advanced_control_one[B_LOOP_DRIVE]) |=> !infrared_transmit_pin)
    else $error("infrared pin driven in plain loopback");
  AST_FAIR_CUT: assert property ( // R11
    st_q.fair_cnt == FAIR_CYCLES && !fair_off |=> !dma_req_ch0 && !dma_req_ch1)
    else $error("dma request not cut after fairness time");
  AST_SWAP_TX: assert property ( // R9
    fair_off && dma_req.single && st_q.advanced_control_one[B_DMA_SWAP] && dma_req.tx
      |=> dma_req_ch0 && !dma_req_ch1)
    else $error("swapped channel not given to transmitter");
  AST_THR_LOW: assert property ( // R10
    !(adv && st_q.advanced_control_one[B_DMA_THR])
      |=> fifo_cfg.tx_thr == TX_THR_LOW && fifo_cfg.rx_thr == RX_THR_LOW)
    else $error("low thresholds wrong");
  AST_PRESC_ONE: assert property ( // R15
    clk_edge && presc_sel == 2'h3 |=> st_q.pre_tick)
    else $error("pre-divisor of one missed an edge");

endmodule : irbm_top

// >>> tb/tb_irbm_top.sv
// Self-checking bench for the infrared baud and mode register bank
`timescale 1ns/1ps
module tb_irbm_top;
  import irbm_pkg::*;
  typedef struct packed {
    logic [2:0]  op;
    logic [11:0] a;
    logic [19:0] d;
  } irbm_row_t;
  logic            aclk = 0, aresetn = 0, clk24 = 0, tx_bit = 0, irx = 0;
  logic [11:0]     awaddr = 0, araddr = 0;
  logic            awvalid = 0, wvalid = 0, arvalid = 0;
  logic [31:0]     wdata = 0, rdata;
  logic            awready, wready, bvalid, arready, rvalid;
  logic [1:0]      bresp, rresp;
  logic            itx, dtr, rxb, ch0, ch1, adv;
  logic [2:0]      mode;
  irbm_dma_req_t   dreq = '0;
  irbm_fifo_cfg_t  cfg;
  irbm_row_t       rows [];
  int              mismatches = 0, compares = 0;
  always #2 aclk = ~aclk;
  // Free-running 24 MHz source, unrelated in phase to the bus clock
  always #21 clk24 = ~clk24;
  irbm_top dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(1'b1), .clk24_pin(clk24), .ir_rx_pin(irx),
    .tx_bit(tx_bit), .tx_fill_level(6'h15), .rx_fill_level(6'h2a),
    .dma_req(dreq), .infrared_transmit_pin(itx), .dtr_pin(dtr),
    .rx_bit(rxb), .dma_req_ch0(ch0), .dma_req_ch1(ch1), .fifo_cfg(cfg),
    .advanced_mode_field(mode), .advanced_enable(adv));
  ////////////////////////////////////////////////////////////////////////////
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task results;
    $display("Compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : results
  // Bus cycles hold ready-high masters; bready and rready stay high
  task automatic wr(input logic [11:0] a, input logic [7:0] d,
                    output logic [1:0] r);
    awaddr <= a; wdata <= {24'h0, d}; awvalid <= 1'b1; wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    r = bresp;
  endtask : wr
  task automatic rd(input logic [11:0] a, output logic [31:0] v,
                    output logic [1:0] r);
    araddr <= a; arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    v = rdata; r = rresp;
  endtask : rd
  function automatic logic [19:0] st(int t, int r, int z, int m, int a);
    return {2'b00, 6'(t), 6'(r), 2'(z), 3'(m), 1'(a)};
  endfunction : st
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #100000;
    mismatches++;
    results();
  end
  initial begin
    logic [31:0] v;
    logic [1:0]  r;
    // Ops: 0 write, 1 read, 2 status pins, 3 loopback pins, 4 dma
    rows = '{'{1, 12'h00c, 20'he0}, '{1, 12'h008, 0}, '{1, 12'h010, 0},
      '{0, 12'h018, 20'h55}, '{1, 12'h018, 20'h15}, '{1, 12'h01c, 20'h2a},
      '{0, 12'h008, 1}, '{2, 0, st(13, 4, 0, 3, 1)},
      '{0, 12'h010, 20'hb5}, '{0, 12'h008, 20'hbf}, '{1, 12'h008, 20'hbf},
      '{2, 0, st(23, 10, 3, 3, 1)}, '{3, 0, 1}, '{3, 0, 0},
      '{4, 0, 20'h15}, '{4, 0, 20'h03}, '{4, 0, 0},
      '{0, 12'h000, 20'h34}, '{1, 12'h000, 20'h34}, '{0, 12'h00c, 0},
      '{0, 12'h010, 20'ha0}, '{0, 12'h00c, 20'h80}, '{1, 12'h010, 20'ha0},
      '{0, 12'h000, 20'h12}, '{2, 0, st(23, 10, 3, 5, 1)},
      '{0, 12'h00c, 20'he0}, '{0, 12'h010, 20'h15}, '{0, 12'h00c, 20'h80},
      '{1, 12'h000, 20'h12}, '{2, 0, st(13, 4, 0, 0, 0)},
      '{0, 12'h00c, 20'he0}, '{1, 12'h008, 20'h1e},
      '{0, 12'h008, 20'ha0}, '{0, 12'h00c, 20'h80}, '{1, 12'h004, 0},
      '{0, 12'h00c, 20'he0}, '{1, 12'h008, 0}, '{0, 12'h008, 20'ha0},
      '{0, 12'h010, 20'h80}, '{0, 12'h00c, 20'h80}, '{0, 12'h000, 20'h77},
      '{0, 12'h00c, 20'he0}, '{1, 12'h008, 20'ha0}, '{1, 12'h000, 20'h77},
      '{0, 12'h000, 20'h99}, '{1, 12'h000, 20'h77}};
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk(32'({cfg, mode, adv}), 32'(st(13, 4, 0, 0, 0)));
    foreach (rows[i]) begin
      case (rows[i].op)
        3'd0: begin
          wr(rows[i].a, rows[i].d[7:0], r);
          chk(32'(r), 32'(RESP_OKAY));
        end
        3'd1: begin
          rd(rows[i].a, v, r);
          chk(v, 32'(rows[i].d));
        end
        3'd2: begin
          repeat (3) @(posedge aclk);
          chk(32'({cfg, mode, adv}), 32'(rows[i].d));
        end
        3'd4: begin
          dreq <= rows[i].d[2:0];
          repeat (3) @(posedge aclk);
          chk(32'({ch0, ch1}), 32'(rows[i].d[4:3]));
        end
        default: begin
          tx_bit <= rows[i].d[0];
          repeat (3) @(posedge aclk);
          chk(32'({itx, rxb}), 32'({2{rows[i].d[0]}}));
        end
      endcase
    end
    // Loopback off: receive pin reaches rx_bit through its synchroniser
    irx <= 1'b1;
    repeat (4) @(posedge aclk);
    chk(32'({itx, rxb}), 32'h1);
    wr(12'h00c, 8'h00, r);
    wr(12'h010, 8'h01, r);
    repeat (2) @(posedge aclk);
    chk(32'(dtr), 32'h1);
    // Request held just past the fairness limit in legacy mode
    dreq <= '{tx: 1'b0, rx: 1'b1, single: 1'b0};
    repeat (10) @(posedge aclk);
    chk(32'({ch0, ch1}), 32'h2);
    repeat (2640) @(posedge aclk);
    chk(32'({ch0, ch1}), 32'h0);
    dreq <= '0;
    wr(12'h100, 8'h5a, r);
    chk(32'(r), 32'(RESP_SLVERR));
    rd(12'h100, v, r);
    chk({v[29:0], r}, 32'(RESP_SLVERR));
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(12'h00c, v, r);
    chk(v, 32'(SSR_RESET));
    rd(12'h008, v, r);
    chk(v, 32'(ADVANCED_CONTROL_ONE_RESET));
    results();
  end
endmodule : tb_irbm_top
